// file: otg_evt_pkg.sv
package otg_evt_pkg;
  localparam logic [11:0] OFS_EVENT_FLAGS  = 12'h004;
  localparam logic [11:0] OFS_BUS_CTRL     = 12'h008;
  localparam logic [11:0] OFS_IRQ_MASK     = 12'h00C;
  localparam logic [31:0] EVENT_RESET      = 32'h00000000;
  localparam logic [31:0] CTRL_RESET       = 32'h00000000;
  localparam logic [31:0] MASK_RESET       = 32'h00000000;
  localparam logic [31:0] EVENT_MASK_BITS  = 32'h000E0304;
  localparam logic [31:0] CTRL_MASK_BITS   = 32'h00000181;
  localparam int          BIT_DEBOUNCE     = 19;
  localparam int          BIT_WAIT_TMO     = 18;
  localparam int          BIT_NEG_REQ      = 17;
  localparam int          BIT_NEG_END      = 9;
  localparam int          BIT_SRQ_END      = 8;
  localparam int          BIT_SES_END      = 2;
  localparam int          BIT_PERIODIC_LVL = 8;
  localparam int          BIT_TX_LVL       = 7;
  localparam int          BIT_GIRQ_EN      = 0;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef struct packed {
    logic debounce_done_flag;
    logic a_side_connect_timeout;
    logic negotiation_request_seen;
    logic negotiation_finished;
    logic session_request_finished;
    logic session_over_flag;
  } otg_events_t;

  typedef struct packed {
    logic periodic_tx_empty_level;
    logic tx_empty_level;
    logic global_irq_enable;
  } ctrl_bits_t;
endpackage

// file: otg_event_irq_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - event flags 0x4, control 0x8, both reset zero
// - bit 19 set when debounce completes
// - bit 18 set on A-device connect timeout
// - bit 17 set on negotiation request detected
// - bit 9 set when negotiation finishes
// - bit 8 picks periodic fifo empty level
// - bit 7 picks tx fifo empty level
// - bit 0 gates the interrupt output
module otg_event_irq_ctrl (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      clk_en,
  input  wire logic [11:0]               s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [11:0]               s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire otg_evt_pkg::otg_events_t  event_pulses,
  output otg_evt_pkg::ctrl_bits_t        ctrl_out,
  output logic                           irq
);

  // write channel: awready/wready pulse when both are present and no response pending
  logic                      aw_ok;
  logic                      wr_fire;
  logic                      rd_fire;
  logic [31:0]               nxt_events;
  logic [31:0]               events_ff;
  logic [31:0]               nxt_ctrl;
  logic [31:0]               ctrl_ff;
  logic [31:0]               nxt_mask;
  logic [31:0]               mask_ff;
  logic [31:0]               set_vec;
  logic                      nxt_awready;
  logic                      nxt_bvalid;
  logic [1:0]                nxt_bresp;
  logic                      nxt_arready;
  logic                      nxt_rvalid;
  logic [31:0]               nxt_rdata;
  logic [1:0]                nxt_rresp;
  logic                      nxt_irq;
  otg_evt_pkg::ctrl_bits_t   nxt_ctrl_out;
  logic                      full_word;

  assign wr_fire   = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign rd_fire   = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  // partial writes are refused with slverr rather than half-updating a flag word
  assign full_word = (s_axi_wstrb == 4'hF);
  assign aw_ok     = full_word && (s_axi_awaddr[1:0] == 2'h0);

  always_comb begin
    set_vec = 32'h00000000;
    set_vec[otg_evt_pkg::BIT_DEBOUNCE] = event_pulses.debounce_done_flag;
    set_vec[otg_evt_pkg::BIT_WAIT_TMO] = event_pulses.a_side_connect_timeout;
    set_vec[otg_evt_pkg::BIT_NEG_REQ]  = event_pulses.negotiation_request_seen;
    set_vec[otg_evt_pkg::BIT_NEG_END]  = event_pulses.negotiation_finished;
    set_vec[otg_evt_pkg::BIT_SRQ_END]  = event_pulses.session_request_finished;
    set_vec[otg_evt_pkg::BIT_SES_END]  = event_pulses.session_over_flag;
  end

  always_comb begin
    nxt_events  = events_ff;
    nxt_ctrl    = ctrl_ff;
    nxt_mask    = mask_ff;
    nxt_awready = 1'b0;
    nxt_bvalid  = s_axi_bvalid && !s_axi_bready;
    nxt_bresp   = s_axi_bresp;
    if (wr_fire) begin
      nxt_awready = 1'b1;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = otg_evt_pkg::RESP_OKAY;
      if (!aw_ok) begin
        nxt_bresp = otg_evt_pkg::RESP_SLVERR;
      end else begin
        case (s_axi_awaddr)
          otg_evt_pkg::OFS_EVENT_FLAGS: begin
            nxt_events = events_ff & ~(s_axi_wdata & otg_evt_pkg::EVENT_MASK_BITS);
          end
          otg_evt_pkg::OFS_BUS_CTRL: begin
            // reserved bits are not stored, so they always read back as zero
            nxt_ctrl = s_axi_wdata & otg_evt_pkg::CTRL_MASK_BITS;
          end
          otg_evt_pkg::OFS_IRQ_MASK: begin
            nxt_mask = s_axi_wdata & otg_evt_pkg::EVENT_MASK_BITS;
          end
          default: begin
            nxt_bresp = otg_evt_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    // hardware set wins over a same-cycle software clear
    nxt_events = nxt_events | set_vec;
  end

  always_comb begin
    nxt_arready = 1'b0;
    nxt_rvalid  = s_axi_rvalid && !s_axi_rready;
    nxt_rdata   = s_axi_rdata;
    nxt_rresp   = s_axi_rresp;
    if (rd_fire) begin
      nxt_arready = 1'b1;
      nxt_rvalid  = 1'b1;
      nxt_rresp   = otg_evt_pkg::RESP_OKAY;
      case (s_axi_araddr)
        otg_evt_pkg::OFS_EVENT_FLAGS: nxt_rdata = events_ff;
        otg_evt_pkg::OFS_BUS_CTRL:    nxt_rdata = ctrl_ff;
        otg_evt_pkg::OFS_IRQ_MASK:    nxt_rdata = mask_ff;
        default: begin
          nxt_rdata = 32'h00000000;
          nxt_rresp = otg_evt_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_comb begin
    nxt_ctrl_out.periodic_tx_empty_level = nxt_ctrl[otg_evt_pkg::BIT_PERIODIC_LVL];
    nxt_ctrl_out.tx_empty_level          = nxt_ctrl[otg_evt_pkg::BIT_TX_LVL];
    nxt_ctrl_out.global_irq_enable       = nxt_ctrl[otg_evt_pkg::BIT_GIRQ_EN];
    nxt_irq = nxt_ctrl[otg_evt_pkg::BIT_GIRQ_EN] && ((nxt_events & nxt_mask) != 32'h00000000);
  end

  // stored registers and the write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      events_ff     <= otg_evt_pkg::EVENT_RESET;
      ctrl_ff       <= otg_evt_pkg::CTRL_RESET;
      mask_ff       <= otg_evt_pkg::MASK_RESET;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= otg_evt_pkg::RESP_OKAY;
    end else if (clk_en) begin
      events_ff     <= nxt_events;
      ctrl_ff       <= nxt_ctrl;
      mask_ff       <= nxt_mask;
      s_axi_awready <= nxt_awready;
      s_axi_wready  <= nxt_awready;
      s_axi_bvalid  <= nxt_bvalid;
      s_axi_bresp   <= nxt_bresp;
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= otg_evt_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= nxt_arready;
      s_axi_rvalid  <= nxt_rvalid;
      s_axi_rdata   <= nxt_rdata;
      s_axi_rresp   <= nxt_rresp;
    end
  end

  // exported bits are built from next values so they never lag the registers by a cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_out      <= '0;
      irq           <= 1'b0;
    end else if (clk_en) begin
      ctrl_out      <= nxt_ctrl_out;
      irq           <= nxt_irq;
    end
  end

  sequence s_flag_write_one;
    clk_en && wr_fire && aw_ok && s_axi_awaddr == otg_evt_pkg::OFS_EVENT_FLAGS
      && s_axi_wdata[otg_evt_pkg::BIT_DEBOUNCE] && !event_pulses.debounce_done_flag;
  endsequence

  a_debounce_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && event_pulses.debounce_done_flag |=> events_ff[19])
    else $error("debounce flag not set");
  a_timeout_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && event_pulses.a_side_connect_timeout |=> events_ff[18])
    else $error("timeout flag not set");
  a_negreq_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && event_pulses.negotiation_request_seen |=> events_ff[17])
    else $error("negotiation request flag not set");
  a_negend_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && event_pulses.negotiation_finished |=> events_ff[9])
    else $error("negotiation end flag not set");
  a_session_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && event_pulses.session_over_flag |=> events_ff[otg_evt_pkg::BIT_SES_END])
    else $error("session end flag not set");
  a_srq_end_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && event_pulses.session_request_finished |=> events_ff[otg_evt_pkg::BIT_SRQ_END])
    else $error("session request end flag not set");
  a_flag_clear_one: assert property (@(posedge aclk) disable iff (!aresetn)
    s_flag_write_one |=> !events_ff[19])
    else $error("write one did not clear flag");
  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    events_ff[18] && !(wr_fire && s_axi_awaddr == otg_evt_pkg::OFS_EVENT_FLAGS) |=> events_ff[18])
    else $error("flag dropped without write");
  a_irq_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_ff[otg_evt_pkg::BIT_GIRQ_EN] |-> !irq)
    else $error("interrupt raised while disabled");
  a_levels_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en |=> ctrl_out.periodic_tx_empty_level == ctrl_ff[8] && ctrl_out.tx_empty_level == ctrl_ff[7])
    else $error("level outputs out of step");
  a_reset_zero: assert property (@(posedge aclk)
    !aresetn |=> events_ff == 32'h00000000 && ctrl_ff == 32'h00000000)
    else $error("registers not zero after reset");

  // bus handshake steps, so the answer checks read as taken, then answered
  sequence s_write_taken;
    clk_en && wr_fire;
  endsequence

  sequence s_read_taken;
    clk_en && rd_fire;
  endsequence

  sequence s_narrow_write;
    clk_en && wr_fire && !full_word;
  endsequence

  sequence s_write_answer_open;
    s_axi_bvalid && !s_axi_bready;
  endsequence

  sequence s_read_answer_open;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_taken |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
    else $error("write not answered one cycle after it was taken");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read_taken |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered one cycle after it was taken");
  a_awready_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && s_axi_awready |=> !s_axi_awready && !s_axi_wready)
    else $error("write ready held beyond one cycle");
  a_arready_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && s_axi_arready |=> !s_axi_arready)
    else $error("read ready held beyond one cycle");
  a_write_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_answer_open |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_read_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read_answer_open |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response changed before rready");
  // a refused write may still see hardware sets, but never a clear or a control change
  a_narrow_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    s_narrow_write |=> s_axi_bresp == otg_evt_pkg::RESP_SLVERR && ctrl_ff == $past(ctrl_ff)
      && mask_ff == $past(mask_ff) && events_ff == ($past(events_ff) | $past(set_vec)))
    else $error("narrow write was not refused");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_ff & ~otg_evt_pkg::CTRL_MASK_BITS) == 32'h00000000
      && (mask_ff & ~otg_evt_pkg::EVENT_MASK_BITS) == 32'h00000000)
    else $error("reserved control or mask bit stored");
  a_mask_gates: assert property (@(posedge aclk) disable iff (!aresetn)
    (events_ff & mask_ff) == 32'h00000000 |-> !irq)
    else $error("interrupt raised with no unmasked flag");
  a_irq_raised: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_ff[otg_evt_pkg::BIT_GIRQ_EN] && (events_ff & mask_ff) != 32'h00000000 |-> irq)
    else $error("interrupt missing for an unmasked flag");
  a_enable_exported: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_out.global_irq_enable == ctrl_ff[otg_evt_pkg::BIT_GIRQ_EN])
    else $error("enable output out of step");
  // clk_en low must freeze everything, flags included
  a_frozen_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_en |=> $stable(events_ff) && $stable(ctrl_ff) && $stable(mask_ff) && $stable(irq))
    else $error("state moved while clock enable was low");

  // one hold, clear and set check per implemented flag bit; reserved bits must stay zero
  for (genvar b = 0; b < 32; b++) begin : g_flag_chk
    if (otg_evt_pkg::EVENT_MASK_BITS[b]) begin : g_used
      a_bit_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        events_ff[b] && !(wr_fire && aw_ok && s_axi_awaddr == otg_evt_pkg::OFS_EVENT_FLAGS && s_axi_wdata[b])
          |=> events_ff[b])
        else $error("flag bit dropped without a write of one");
      a_bit_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && wr_fire && aw_ok && s_axi_awaddr == otg_evt_pkg::OFS_EVENT_FLAGS && s_axi_wdata[b] && !set_vec[b]
          |=> !events_ff[b])
        else $error("write of one left flag bit set");
      a_bit_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && set_vec[b] |=> events_ff[b])
        else $error("event did not set its flag bit");
    end else begin : g_unused
      a_bit_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
        !events_ff[b])
        else $error("reserved flag bit set");
    end
  end

endmodule

// file: test_usb_otg_event_and_irq_control.sv
`timescale 1ns/1ps
module test_usb_otg_event_and_irq_control;
  logic                     aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic                     s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, clk_en;
  logic [11:0]              s_axi_awaddr, s_axi_araddr;
  logic [31:0]              s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]               s_axi_wstrb;
  logic [1:0]               s_axi_bresp, s_axi_rresp, resp;
  otg_evt_pkg::otg_events_t event_pulses;
  otg_evt_pkg::ctrl_bits_t  ctrl_out;
  int                       err_total, checks_done, i, pos [6], cpos [3];

  otg_event_irq_ctrl i_otg_event_irq_ctrl (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .event_pulses(event_pulses), .ctrl_out(ctrl_out), .irq(irq));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // the whole write is one bounded wait; bvalid may arrive at the same edge as awready
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 20) begin
      err_total++;
      end_of_test();
    end
  endtask

  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rd_data = s_axi_rdata;
        resp    = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 20) begin
      err_total++;
      end_of_test();
    end
  endtask

  task automatic chk_ev(input logic [31:0] exp);
    rd(otg_evt_pkg::OFS_EVENT_FLAGS);
    cmp(rd_data, exp);
  endtask

  task automatic pulse(input logic [5:0] e);
    @(posedge aclk);
    event_pulses <= e;
    @(posedge aclk);
    event_pulses <= '0;
  endtask

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, event_pulses} = '0;
    err_total = 0;
    checks_done = 0;
    clk_en = 1'b1;
    pos = '{otg_evt_pkg::BIT_SES_END, otg_evt_pkg::BIT_SRQ_END, otg_evt_pkg::BIT_NEG_END,
            otg_evt_pkg::BIT_NEG_REQ, otg_evt_pkg::BIT_WAIT_TMO, otg_evt_pkg::BIT_DEBOUNCE};
    cpos = '{otg_evt_pkg::BIT_GIRQ_EN, otg_evt_pkg::BIT_TX_LVL, otg_evt_pkg::BIT_PERIODIC_LVL};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk_ev(otg_evt_pkg::EVENT_RESET);
    rd(otg_evt_pkg::OFS_BUS_CTRL);
    cmp(rd_data, otg_evt_pkg::CTRL_RESET);
    cmp({28'h0, ctrl_out, irq}, 32'h0);
    for (i = 0; i < 3; i++) begin
      wr(otg_evt_pkg::OFS_BUS_CTRL, 32'h1 << cpos[i], 4'hF);
      rd(otg_evt_pkg::OFS_BUS_CTRL);
      cmp(rd_data, 32'h1 << cpos[i]);
      cmp({29'h0, ctrl_out}, 32'h1 << i);
    end
    for (i = 0; i < 6; i++) begin
      pulse(6'h01 << i);
      chk_ev(32'h1 << pos[i]);
      wr(otg_evt_pkg::OFS_EVENT_FLAGS, otg_evt_pkg::EVENT_MASK_BITS & ~(32'h1 << pos[i]), 4'hF);
      chk_ev(32'h1 << pos[i]);
      wr(otg_evt_pkg::OFS_EVENT_FLAGS, 32'h1 << pos[i], 4'hF);
      chk_ev(32'h0);
    end
    // a frozen clock enable must swallow an event pulse
    @(posedge aclk);
    clk_en <= 1'b0;
    pulse(6'h10);
    clk_en <= 1'b1;
    chk_ev(32'h0);
    wr(otg_evt_pkg::OFS_BUS_CTRL, 32'h1, 4'hF);
    pulse(6'h20);
    repeat (2) @(posedge aclk);
    cmp({31'h0, irq}, 32'h0);
    wr(otg_evt_pkg::OFS_IRQ_MASK, otg_evt_pkg::EVENT_MASK_BITS, 4'hF);
    rd(otg_evt_pkg::OFS_IRQ_MASK);
    cmp(rd_data, otg_evt_pkg::EVENT_MASK_BITS);
    repeat (2) @(posedge aclk);
    cmp({31'h0, irq}, 32'h1);
    wr(otg_evt_pkg::OFS_BUS_CTRL, 32'h0, 4'hF);
    repeat (2) @(posedge aclk);
    cmp({31'h0, irq}, 32'h0);
    // a narrow write is refused and must not clear the flag
    wr(otg_evt_pkg::OFS_EVENT_FLAGS, 32'h00080000, 4'h3);
    cmp({30'h0, resp}, {30'h0, otg_evt_pkg::RESP_SLVERR});
    chk_ev(32'h00080000);
    rd(12'h010);
    cmp({30'h0, resp}, {30'h0, otg_evt_pkg::RESP_SLVERR});
    cmp(rd_data, 32'h0);
    wr(otg_evt_pkg::OFS_BUS_CTRL, 32'h1, 4'hF);
    repeat (2) @(posedge aclk);
    cmp({31'h0, irq}, 32'h1);
    wr(otg_evt_pkg::OFS_EVENT_FLAGS, 32'h00080000, 4'hF);
    repeat (2) @(posedge aclk);
    cmp({31'h0, irq}, 32'h0);
    // a second reset in mid-run must clear what was stored
    wr(otg_evt_pkg::OFS_BUS_CTRL, 32'h00000181, 4'hF);
    pulse(6'h3F);
    @(posedge aclk);
    cmp({28'h0, ctrl_out, irq}, 32'hF);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    cmp({28'h0, ctrl_out, irq}, 32'h0);
    chk_ev(otg_evt_pkg::EVENT_RESET);
    rd(otg_evt_pkg::OFS_BUS_CTRL);
    cmp(rd_data, otg_evt_pkg::CTRL_RESET);
    rd(otg_evt_pkg::OFS_IRQ_MASK);
    cmp(rd_data, otg_evt_pkg::MASK_RESET);
    end_of_test();
  end
endmodule
